// *** core/eight_bit_timer_compare.sv ***
`timescale 1ns/100ps
`default_nettype none
// Function
// [RULE_01] Prescaler divides tick by 1 to 128.
// [RULE_02] New prescale selection takes effect immediately.
// [RULE_03] Run bit low suspends counting; resets low.
// [RULE_04] Writing clear forces counter zero; reads zero.
// [RULE_05] Clear bit reads zero after sleep wakeup.
// [RULE_06] Free mode counts 00 to FF, wraps.
// [RULE_07] Down mode counts from level to zero.
// [RULE_08] Modulo mode counts zero up to level.
// [RULE_09] Up/down mode bounces between zero and level.
// [RULE_10] Counter value readable, read-only, resets zero.
// [RULE_11] Overflow interrupt gated by mask, resets one.
// [RULE_12] Channel 0 level register bounds counting.
// [RULE_13] Channel 1 level register for channel 1.
// [RULE_14] Channel 1 compare acts only when enabled.
// [RULE_15] Action taken when counter equals level.
// [RULE_16] Codes 000/001/010 set, clear, toggle.
// [RULE_17] Code 011 set up-match, clear zero/down-match.
// [RULE_18] Code 100 clear up-match, set zero/down-match.
// [RULE_19] Code 101 set on match, clear at level0.
// [RULE_20] Code 110 clear on match, set at level0.
// [RULE_21] Channel interrupt forwarded only when mask set.
module eight_bit_timer_compare (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Timer tick and wakeup pulse, both on clk.
   input wire logic tick,
   input wire logic wake,
   // Register port.
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // Compare output and interrupt requests.
   output logic ch1_out,
   output logic ovf_irq,
   output logic ch1_irq
);

   // ======================================================================
   // State and decoded strobes.
   tmr_pkg::timer_state_t s_q; // Registered state.
   tmr_pkg::timer_state_t s_d; // Next state.
   logic act; // Active prescaled counter edge.
   logic clr_wr; // Software clear request this cycle.
   logic load_lvl; // Down mode start loads the level this cycle.
   logic [tmr_pkg::PRESC_W-1:0] div_mask; // Low prescaler bits to test.

   // Builds the mask of prescaler bits that must be zero for an edge.
   function automatic logic [tmr_pkg::PRESC_W-1:0] mask_of(
      input logic [2:0] sel);
      logic [tmr_pkg::PRESC_W:0] one_hot;
      one_hot = '0;
      one_hot[sel] = 1'b1;
      return one_hot[tmr_pkg::PRESC_W-1:0] - 7'h01;
   endfunction

   // Edge and clear decode; the mask uses the live selection.
   always_comb begin
      div_mask = mask_of(s_q.prescale_select);
      act = tick && ((s_q.presc & div_mask) == 7'h00); // RULE_01 RULE_02
      clr_wr = wr && (addr == tmr_pkg::ADDR_CONTROL)
         && wdata[tmr_pkg::CTL_CLR_BIT] && !wake; // RULE_04 RULE_05
      // Starting down mode from any other state loads the channel 0
      // level; a clear written in the same cycle still wins.
      load_lvl = wr && (addr == tmr_pkg::ADDR_CONTROL)
         && wdata[tmr_pkg::CTL_RUN_BIT]
         && (wdata[tmr_pkg::CTL_MODE_LSB +: 2] == tmr_pkg::MODE_DOWN)
         && !(s_q.run && (s_q.count_mode_select == tmr_pkg::MODE_DOWN))
         && !clr_wr; // RULE_07
   end

   // ======================================================================
   // Next-state logic.
   always_comb begin
      logic step;
      logic match;
      logic went_down;
      logic ovf;
      step = 1'b0;
      match = 1'b0;
      went_down = 1'b0;
      ovf = 1'b0;
      s_d = s_q;
      s_d.ovf_irq = 1'b0;
      s_d.ch1_irq = 1'b0;
      // The prescaler runs on every tick so the edge grid stays steady.
      if (tick) begin
         s_d.presc = s_q.presc + 7'h01;
      end
      // Counting, only while running and on an active edge.
      if (s_q.run && act) begin // RULE_03
         step = 1'b1;
         case (s_q.count_mode_select)
            tmr_pkg::MODE_FREE: begin // RULE_06
               s_d.count_byte = s_q.count_byte + 8'h01;
               s_d.dir_down = 1'b0;
               ovf = (s_q.count_byte == tmr_pkg::MAX_COUNT);
            end
            tmr_pkg::MODE_DOWN: begin // RULE_07
               // The start loaded the level; each edge steps one down until zero, then holds.
               s_d.dir_down = 1'b1;
               if (s_q.count_byte != 8'h00) begin
                  s_d.count_byte = s_q.count_byte - 8'h01;
                  ovf = (s_q.count_byte == 8'h01);
               end else begin
                  step = 1'b0;
               end
            end
            tmr_pkg::MODE_MODULO: begin // RULE_08
               s_d.dir_down = 1'b0;
               if (s_q.count_byte >= s_q.ch0_level) begin
                  s_d.count_byte = 8'h00;
                  ovf = 1'b1;
               end else begin
                  s_d.count_byte = s_q.count_byte + 8'h01;
               end
            end
            tmr_pkg::MODE_UPDOWN: begin // RULE_09
               if (!s_q.dir_down) begin
                  if (s_q.count_byte >= s_q.ch0_level) begin
                     // Turn around at the top.
                     s_d.dir_down = (s_q.count_byte != 8'h00);
                     if (s_q.count_byte != 8'h00) begin
                        s_d.count_byte = s_q.count_byte - 8'h01;
                        ovf = (s_q.count_byte == 8'h01);
                     end
                  end else begin
                     s_d.count_byte = s_q.count_byte + 8'h01;
                  end
               end else if (s_q.count_byte == 8'h00) begin
                  // Turn around at the bottom.
                  s_d.dir_down = 1'b0;
                  if (s_q.ch0_level != 8'h00) begin
                     s_d.count_byte = 8'h01;
                  end
               end else begin
                  s_d.count_byte = s_q.count_byte - 8'h01;
                  ovf = (s_q.count_byte == 8'h01);
               end
            end
            default: begin
               step = 1'b0;
            end
         endcase
      end
      went_down = s_d.dir_down;
      // Channel 1 compare on the value just reached.
      match = (s_d.count_byte == s_q.ch1_level); // RULE_15
      if (step && s_q.channel_compare_enable) begin // RULE_14
         case (s_q.output_action_select)
            tmr_pkg::ACT_SET: begin // RULE_16
               if (match) s_d.ch1_out = 1'b1;
            end
            tmr_pkg::ACT_CLEAR: begin
               if (match) s_d.ch1_out = 1'b0;
            end
            tmr_pkg::ACT_TOGGLE: begin
               if (match) s_d.ch1_out = !s_q.ch1_out;
            end
            tmr_pkg::ACT_SET_UP: begin // RULE_17
               if (match && !went_down) begin
                  s_d.ch1_out = 1'b1;
               end else if (s_q.count_mode_select == tmr_pkg::MODE_UPDOWN
                  ? (match && went_down) : (s_d.count_byte == 8'h00)) begin
                  s_d.ch1_out = 1'b0;
               end
            end
            tmr_pkg::ACT_CLR_UP: begin // RULE_18
               if (match && !went_down) begin
                  s_d.ch1_out = 1'b0;
               end else if (s_q.count_mode_select == tmr_pkg::MODE_UPDOWN
                  ? (match && went_down) : (s_d.count_byte == 8'h00)) begin
                  s_d.ch1_out = 1'b1;
               end
            end
            tmr_pkg::ACT_SET_CC0: begin // RULE_19
               if (match) begin
                  s_d.ch1_out = 1'b1;
               end else if (s_d.count_byte == s_q.ch0_level) begin
                  s_d.ch1_out = 1'b0;
               end
            end
            tmr_pkg::ACT_CLR_CC0: begin // RULE_20
               if (match) begin
                  s_d.ch1_out = 1'b0;
               end else if (s_d.count_byte == s_q.ch0_level) begin
                  s_d.ch1_out = 1'b1;
               end
            end
            default: begin
               // Code 111 leaves the output alone.
            end
         endcase
      end
      // Interrupt requests, each gated by its mask.
      s_d.ovf_irq = ovf && s_q.overflow_irq_mask; // RULE_11
      s_d.ch1_irq = step && match && s_q.channel_compare_enable
         && s_q.channel_irq_mask; // RULE_21
      // A software clear wins over counting.
      if (clr_wr) begin // RULE_04
         s_d.count_byte = tmr_pkg::RST_COUNT;
         s_d.dir_down = 1'b0;
      end
      // Register writes; the counter register ignores writes.
      if (wr) begin // RULE_10
         case (addr)
            tmr_pkg::ADDR_CH0_LEVEL: s_d.ch0_level = wdata; // RULE_12
            tmr_pkg::ADDR_CH1_LEVEL: s_d.ch1_level = wdata; // RULE_13
            tmr_pkg::ADDR_CH1_CTRL: begin
               s_d.channel_irq_mask = wdata[tmr_pkg::CC1_IM_BIT];
               s_d.output_action_select = tmr_pkg::out_action_t'(
                  wdata[tmr_pkg::CC1_CMP_LSB +: 3]);
               s_d.channel_compare_enable = wdata[tmr_pkg::CC1_EN_BIT];
               s_d.reserved = wdata[tmr_pkg::CC1_RSV_LSB +: 2];
            end
            tmr_pkg::ADDR_CONTROL: begin
               s_d.prescale_select = wdata[tmr_pkg::CTL_DIV_LSB +: 3];
               s_d.run = wdata[tmr_pkg::CTL_RUN_BIT];
               s_d.overflow_irq_mask = wdata[tmr_pkg::CTL_OVERFLOW_IRQ_MASK_BIT];
               s_d.count_mode_select = tmr_pkg::count_mode_t'(
                  wdata[tmr_pkg::CTL_MODE_LSB +: 2]);
               // Down mode starts from the channel 0 level.
               if (load_lvl) begin // RULE_07
                  s_d.count_byte = s_q.ch0_level;
                  s_d.dir_down = 1'b1;
               end
            end
            default: begin
               // Other addresses are ignored.
            end
         endcase
      end
      // Read data for the next cycle; the clear bit always reads zero.
      s_d.rdata = 8'h00;
      if (rd) begin
         case (addr)
            tmr_pkg::ADDR_CH0_LEVEL: s_d.rdata = s_q.ch0_level;
            tmr_pkg::ADDR_CH1_LEVEL: s_d.rdata = s_q.ch1_level;
            tmr_pkg::ADDR_COUNTER: s_d.rdata = s_q.count_byte; // RULE_10
            tmr_pkg::ADDR_CH1_CTRL: begin
               s_d.rdata = {1'b0, s_q.channel_irq_mask,
                  s_q.output_action_select, s_q.channel_compare_enable,
                  s_q.reserved};
            end
            tmr_pkg::ADDR_CONTROL: begin // RULE_05
               s_d.rdata = {s_q.prescale_select, s_q.run,
                  s_q.overflow_irq_mask, 1'b0, s_q.count_mode_select};
            end
            default: begin
               s_d.rdata = 8'h00;
            end
         endcase
      end
   end

   // ======================================================================
   // State register.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '{count_byte: tmr_pkg::RST_COUNT, dir_down: 1'b0,
            presc: '0, prescale_select: tmr_pkg::RST_DIV,
            run: tmr_pkg::RST_RUN, overflow_irq_mask: tmr_pkg::RST_OVERFLOW_IRQ_MASK,
            count_mode_select: tmr_pkg::MODE_FREE,
            ch0_level: tmr_pkg::RST_LEVEL, ch1_level: tmr_pkg::RST_LEVEL,
            channel_irq_mask: tmr_pkg::RST_IM,
            output_action_select: tmr_pkg::ACT_SET,
            channel_compare_enable: tmr_pkg::RST_EN, reserved: 2'h0,
            ch1_out: 1'b0, rdata: 8'h00, ovf_irq: 1'b0, ch1_irq: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs come straight from the state register.
   assign rdata = s_q.rdata;
   assign ch1_out = s_q.ch1_out;
   assign ovf_irq = s_q.ovf_irq;
   assign ch1_irq = s_q.ch1_irq;

   // ======================================================================
   // Assertions.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   edge_tick_a: assert property (act |-> tick) // RULE_01
      else $error("Counter edge without a tick.");
   hold_susp_a: assert property (!s_q.run && !clr_wr && !load_lvl // RULE_03
      |=> $stable(s_q.count_byte))
      else $error("Counter moved while stopped.");
   clear_zero_a: assert property (clr_wr |=> // RULE_04
      s_q.count_byte == 8'h00) else $error("Clear did not zero counter.");
   clr_read_a: assert property (rd && addr == tmr_pkg::ADDR_CONTROL // RULE_05
      |=> !rdata[tmr_pkg::CTL_CLR_BIT]) else $error("Clear bit read as one.");
   free_wrap_a: assert property (s_q.run && act && !clr_wr // RULE_06
      && !load_lvl && s_q.count_mode_select == tmr_pkg::MODE_FREE
      && s_q.count_byte == 8'hff |=> s_q.count_byte == 8'h00)
      else $error("Free mode did not wrap.");
   down_step_a: assert property (s_q.run && act && !clr_wr // RULE_07
      && s_q.count_mode_select == tmr_pkg::MODE_DOWN
      && s_q.count_byte != 8'h00
      |=> s_q.count_byte == $past(s_q.count_byte) - 8'h01)
      else $error("Down mode did not decrement.");
   mod_wrap_a: assert property (s_q.run && act && !clr_wr // RULE_08
      && !load_lvl && s_q.count_mode_select == tmr_pkg::MODE_MODULO
      && s_q.count_byte == s_q.ch0_level |=> s_q.count_byte == 8'h00)
      else $error("Modulo mode did not restart.");
   ovf_mask_a: assert property (ovf_irq |-> // RULE_11
      $past(s_q.overflow_irq_mask)) else $error("Masked overflow request.");
   ch1_mask_a: assert property (ch1_irq // RULE_21
      |-> $past(s_q.channel_irq_mask) && $past(s_q.channel_compare_enable))
      else $error("Masked channel request.");
   cnt_read_a: assert property (rd && addr == tmr_pkg::ADDR_COUNTER // RULE_10
      |=> rdata == $past(s_q.count_byte)) else $error("Bad counter read.");
   ch1_set_a: assert property (s_q.run && act && // RULE_16
      s_q.channel_compare_enable
      && s_q.output_action_select == tmr_pkg::ACT_SET
      && s_q.count_mode_select == tmr_pkg::MODE_FREE
      && s_q.count_byte + 8'h01 == s_q.ch1_level |=> ch1_out)
      else $error("Set action missed.");

   // Down mode start, channel enable and up/down turn checks.
   down_load_a: assert property (load_lvl |=> // RULE_07
      s_q.count_byte == $past(s_q.ch0_level))
      else $error("Down mode did not load the level.");
   ch1_off_a: assert property (!s_q.channel_compare_enable // RULE_14
      |=> $stable(ch1_out)) else $error("Output moved while disabled.");
   ud_turn_a: assert property (s_q.run && act && !clr_wr // RULE_09
      && s_q.count_mode_select == tmr_pkg::MODE_UPDOWN && !s_q.dir_down
      && s_q.count_byte == s_q.ch0_level && s_q.ch0_level != 8'h00
      |=> s_q.dir_down) else $error("Up/down did not turn at the level.");

   free_wrap_c: cover property (ovf_irq);
   ch1_hit_c: cover property (ch1_irq);
   updown_turn_c: cover property (s_q.count_mode_select ==
      tmr_pkg::MODE_UPDOWN && $rose(s_q.dir_down));
   down_halt_c: cover property (s_q.count_mode_select ==
      tmr_pkg::MODE_DOWN && s_q.run && s_q.count_byte == 8'h00);

endmodule // eight_bit_timer_compare
`default_nettype wire

// *** core/tmr_pkg.sv ***
`default_nettype none
// ==========================================================================
// Shared constants and types for the eight-bit timer.
package tmr_pkg;
   // Register byte addresses on the special-function space.
   localparam logic [7:0] ADDR_CH0_LEVEL = 8'hcd;
   localparam logic [7:0] ADDR_CH1_CTRL = 8'hce;
   localparam logic [7:0] ADDR_CH1_LEVEL = 8'hcf;
   localparam logic [7:0] ADDR_COUNTER = 8'hea;
   localparam logic [7:0] ADDR_CONTROL = 8'heb;
   // Control register field positions.
   localparam int CTL_DIV_LSB = 5;
   localparam int CTL_RUN_BIT = 4;
   localparam int CTL_OVERFLOW_IRQ_MASK_BIT = 3;
   localparam int CTL_CLR_BIT = 2;
   localparam int CTL_MODE_LSB = 0;
   // Channel 1 control field positions.
   localparam int CC1_IM_BIT = 6;
   localparam int CC1_CMP_LSB = 3;
   localparam int CC1_EN_BIT = 2;
   localparam int CC1_RSV_LSB = 0;
   // Reset values, the top count and the prescaler width.
   localparam logic [7:0] RST_LEVEL = 8'h00;
   localparam logic [7:0] RST_COUNT = 8'h00;
   localparam logic [7:0] MAX_COUNT = 8'hff;
   localparam logic [2:0] RST_DIV = 3'h0;
   localparam logic [2:0] RST_CMP = 3'h0;
   localparam logic RST_RUN = 1'b0;
   localparam logic RST_OVERFLOW_IRQ_MASK = 1'b1;
   localparam logic RST_IM = 1'b1;
   localparam logic RST_EN = 1'b0;
   localparam int PRESC_W = 7;
   // Counting modes.
   typedef enum logic [1:0] {
      MODE_FREE = 2'h0,
      MODE_DOWN = 2'h1,
      MODE_MODULO = 2'h2,
      MODE_UPDOWN = 2'h3
   } count_mode_t;
   // Channel 1 output actions.
   typedef enum logic [2:0] {
      ACT_SET = 3'h0,
      ACT_CLEAR = 3'h1,
      ACT_TOGGLE = 3'h2,
      ACT_SET_UP = 3'h3,
      ACT_CLR_UP = 3'h4,
      ACT_SET_CC0 = 3'h5,
      ACT_CLR_CC0 = 3'h6,
      ACT_NONE = 3'h7
   } out_action_t;
   // Whole state of the timer.
   typedef struct packed {
      logic [7:0] count_byte;
      logic dir_down;
      logic [PRESC_W-1:0] presc;
      logic [2:0] prescale_select;
      logic run;
      logic overflow_irq_mask;
      count_mode_t count_mode_select;
      logic [7:0] ch0_level;
      logic [7:0] ch1_level;
      logic channel_irq_mask;
      out_action_t output_action_select;
      logic channel_compare_enable;
      logic [1:0] reserved;
      logic ch1_out;
      logic [7:0] rdata;
      logic ovf_irq;
      logic ch1_irq;
   } timer_state_t;
endpackage
`default_nettype wire

// *** tb/eight_bit_timer_compare_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the eight-bit timer with channel 1 compare.
`define CHK(what, e, g) begin compares++; if ((g) !== (e)) begin \
   mismatches++; $display("BAD %s expected %h seen %h", what, e, g); end end
module eight_bit_timer_compare_bench;
   // ==========================================================
   // Signals driven into the block and seen from it.
   logic clk, rst_b, tick, wake, wr, rd;
   logic [7:0] addr, wdata, rdata;
   logic ch1_out, ovf_irq, ch1_irq;
   int mismatches = 0; // Count of failed comparisons.
   int compares = 0; // Count of comparisons made.
   int ovf_n = 0; // Overflow requests seen.
   int ch1_n = 0; // Channel 1 requests seen.
   logic [15:0] exp_q[$]; // Pending reads: address and expected data.
   logic [15:0] ent;
   logic rd_seen = 1'b0; // A read was taken at the previous edge.
   logic [31:0] seed = 32'hdc6b;
   logic [7:0] lvl, v;
   logic [6:0] tbl [10];
   int m, base, irq_base;

   eight_bit_timer_compare uut (.clk(clk), .rst_b(rst_b), .tick(tick),
      .wake(wake), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .ch1_out(ch1_out), .ovf_irq(ovf_irq),
      .ch1_irq(ch1_irq));

   // ==========================================================
   // Clock at 100 ns period.
   always #50 clk = ~clk;

   // Next pseudo-random value from the xorshift sequence.
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Builds a control byte from its fields.
   function automatic logic [7:0] cv(input logic [2:0] dv, input logic r,
         input logic om, input logic cl, input logic [1:0] md);
      return {dv, r, om, cl, md};
   endfunction

   // ==========================================================
   // Bus, tick and reset tasks; all drive right after a rising edge.
   task automatic do_reset();
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d,
         input logic wk);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      wake <= wk;
      @(posedge clk);
      wr <= 1'b0;
      wake <= 1'b0;
   endtask

   // The expected value is noted now and compared by the monitor.
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      exp_q.push_back({a, e});
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
   endtask

   // Holds tick high for exactly n sampling edges.
   task automatic tick_n(input int n);
      if (n > 0) begin
         @(posedge clk);
         tick <= 1'b1;
         repeat (n) @(posedge clk);
         tick <= 1'b0;
      end
   endtask

   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ==========================================================
   // Monitor: read data stands only in the cycle after the strobe.
   always @(posedge clk) begin
      rd_seen <= rd;
      if (ovf_irq === 1'b1) ovf_n++;
      if (ch1_irq === 1'b1) ch1_n++;
      if (rd_seen) begin
         if (exp_q.size() == 0) begin
            mismatches++;
            $display("BAD read queue expected entry seen none");
         end else begin
            ent = exp_q.pop_front();
            `CHK("read data", ent[7:0], rdata)
         end
      end
   end

   // Watchdog that cuts a hung run short.
   initial begin
      repeat (100000) @(posedge clk);
      mismatches++;
      $display("BAD watchdog expected end seen timeout");
      tally_and_finish();
   end

   // ==========================================================
   // Main sequence.
   initial begin
      clk = 1'b0; rst_b = 1'b0; tick = 1'b0; wake = 1'b0;
      wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00;
      // Entries: enable, mask, action, output after 15, after 256.
      tbl = '{7'b0100000, 7'b1100011, 7'b1100100, 7'b1101011,
         7'b1001000, 7'b1101110, 7'b1110001, 7'b1110110,
         7'b1111001, 7'b1111111};
      do_reset();
      // Reset values, access kinds and an unmapped place.
      rd_reg(8'heb, 8'h08);
      rd_reg(8'hce, 8'h40);
      rd_reg(8'hcd, 8'h00);
      rd_reg(8'hcf, 8'h00);
      rd_reg(8'hea, 8'h00);
      v = 8'(rnd());
      wr_reg(8'hcd, v, 1'b0);
      wr_reg(8'hcf, ~v, 1'b0);
      wr_reg(8'hce, 8'hff, 1'b0);
      wr_reg(8'hea, 8'h55, 1'b0);
      wr_reg(8'h10, v, 1'b0);
      rd_reg(8'hcd, v);
      rd_reg(8'hcf, ~v);
      rd_reg(8'hce, 8'h7f);
      rd_reg(8'hea, 8'h00);
      rd_reg(8'h10, 8'h00);
      $display("test registers done");
      // Every divider code: m active edges from m*2^k ticks.
      for (int k = 0; k < 8; k++) begin
         do_reset();
         m = 1 + rnd() % 3;
         wr_reg(8'heb, cv(3'(k), 1'b1, 1'b1, 1'b0, 2'h0), 1'b0);
         tick_n(m << k);
         rd_reg(8'hea, m[7:0]);
         rd_reg(8'heb, cv(3'(k), 1'b1, 1'b1, 1'b0, 2'h0));
      end
      $display("test prescaler done");
      // Divider change acts at once, mid-period.
      do_reset();
      wr_reg(8'heb, cv(3'h7, 1'b1, 1'b1, 1'b0, 2'h0), 1'b0);
      tick_n(64);
      wr_reg(8'heb, cv(3'h0, 1'b1, 1'b1, 1'b0, 2'h0), 1'b0);
      tick_n(5);
      rd_reg(8'hea, 8'h06);
      // Suspended counter ignores ticks.
      do_reset();
      wr_reg(8'heb, cv(3'h0, 1'b0, 1'b1, 1'b0, 2'h0), 1'b0);
      tick_n(5);
      rd_reg(8'hea, 8'h00);
      $display("test divider change and run done");
      // Free running wrap, overflow with mask set then cleared.
      do_reset();
      base = ovf_n;
      wr_reg(8'heb, cv(3'h0, 1'b1, 1'b1, 1'b0, 2'h0), 1'b0);
      tick_n(255);
      rd_reg(8'hea, 8'hff);
      tick_n(1);
      rd_reg(8'hea, 8'h00);
      `CHK("overflow count", base + 1, ovf_n)
      wr_reg(8'heb, cv(3'h0, 1'b1, 1'b0, 1'b0, 2'h0), 1'b0);
      tick_n(256);
      rd_reg(8'hea, 8'h00);
      `CHK("masked overflow count", base + 1, ovf_n)
      // Clear during wakeup is dropped; a plain clear zeroes the count.
      tick_n(5);
      wr_reg(8'heb, cv(3'h0, 1'b1, 1'b0, 1'b1, 2'h0), 1'b1);
      rd_reg(8'hea, 8'h05);
      rd_reg(8'heb, cv(3'h0, 1'b1, 1'b0, 1'b0, 2'h0));
      wr_reg(8'heb, cv(3'h0, 1'b1, 1'b0, 1'b1, 2'h0), 1'b0);
      rd_reg(8'hea, 8'h00);
      $display("test free mode and clear done");
      // Down mode starts from the channel 0 level and halts at zero.
      do_reset();
      base = ovf_n;
      lvl = 8'(8'h08 + rnd() % 8);
      wr_reg(8'hcd, lvl, 1'b0);
      wr_reg(8'heb, cv(3'h0, 1'b1, 1'b1, 1'b0, 2'h0), 1'b0);
      tick_n(5);
      wr_reg(8'heb, cv(3'h0, 1'b1, 1'b1, 1'b0, 2'h1), 1'b0);
      tick_n(3);
      rd_reg(8'hea, lvl - 8'h03);
      tick_n(lvl);
      rd_reg(8'hea, 8'h00);
      `CHK("down overflow count", base + 1, ovf_n)
      // Modulo mode restarts after the channel 0 level.
      do_reset();
      base = ovf_n;
      lvl = 8'(8'h03 + rnd() % 8);
      wr_reg(8'hcd, lvl, 1'b0);
      wr_reg(8'heb, cv(3'h0, 1'b1, 1'b1, 1'b0, 2'h2), 1'b0);
      tick_n(lvl + 3);
      rd_reg(8'hea, 8'h02);
      `CHK("modulo overflow count", base + 1, ovf_n)
      // Up/down mode turns at the channel 0 level.
      do_reset();
      base = ovf_n;
      lvl = 8'(8'h04 + rnd() % 8);
      wr_reg(8'hcd, lvl, 1'b0);
      wr_reg(8'heb, cv(3'h0, 1'b1, 1'b1, 1'b0, 2'h3), 1'b0);
      tick_n(lvl + 2);
      rd_reg(8'hea, lvl - 8'h02);
      tick_n(lvl - 2);
      rd_reg(8'hea, 8'h00);
      `CHK("updown overflow count", base + 1, ovf_n)
      $display("test bounded modes done");
      // Channel 1 actions over one full free-running lap each.
      do_reset();
      wr_reg(8'hcd, 8'h14, 1'b0);
      wr_reg(8'hcf, 8'h0a, 1'b0);
      wr_reg(8'heb, cv(3'h0, 1'b1, 1'b1, 1'b0, 2'h0), 1'b0);
      for (int i = 0; i < 10; i++) begin
         irq_base = ch1_n;
         wr_reg(8'hce, {1'b0, tbl[i][5], tbl[i][4:2], tbl[i][6], 2'h0},
            1'b0);
         // One idle edge lets the output of the last step settle.
         tick_n(15);
         @(posedge clk);
         `CHK("output mid lap", tbl[i][1], ch1_out)
         tick_n(241);
         @(posedge clk);
         `CHK("output end lap", tbl[i][0], ch1_out)
         if (i < 9) begin
            irq_base += int'(tbl[i][6] & tbl[i][5]);
            `CHK("channel irq", irq_base, ch1_n)
         end
      end
      $display("test channel 1 actions done");
      repeat (3) @(posedge clk);
      tally_and_finish();
   end
endmodule // eight_bit_timer_compare_bench
`default_nettype wire
